// [hw/srxa_pkg.sv]
// Purpose: shared constants and types of the receive lock and word aligner
// Assumes: APB register map, 32-bit data, one aligned word per register
// Notes: control, mode and status layouts are packed structs below
package srxa_pkg;

	// register byte offsets
	localparam logic [7:0] SRXA_OFS_CTRL = 8'h00;
	localparam logic [7:0] SRXA_OFS_MODE = 8'h04;
	localparam logic [7:0] SRXA_OFS_PAT = 8'h08;
	localparam logic [7:0] SRXA_OFS_RUNLEN = 8'h0C;
	localparam logic [7:0] SRXA_OFS_STAT = 8'h10;

	typedef enum logic [2:0] {AM_SLIP, AM_P16, AM_P10, AM_XAUI,
		AM_GIGABIT_ETHERNET} srxa_amode_e;
	typedef enum logic [1:0] {PR_CUSTOM, PR_SONET, PR_XAUI,
		PR_GIGABIT_ETHERNET} srxa_proto_e;
	typedef enum logic [1:0] {SY_LOSS, SY_ACQ, SY_SYNC} srxa_sync_e;

	// control register layout, lsb last
	typedef struct packed {
		logic quad;
		logic low7;
		logic chan_used;
		logic dbl;
		logic wide10;
		logic [1:0] ppm_sel;
		logic frc_ref;
		logic frc_data;
	} srxa_ctrl_s;

	// mode register layout
	typedef struct packed {
		srxa_proto_e proto;
		srxa_amode_e amode;
	} srxa_mode_s;

	// status register layout
	typedef struct packed {
		logic in_sync;
		logic runlen_err;
		logic unit_off;
		logic ref_locked_n;
		logic freq_locked;
		logic realign_armed;
	} srxa_stat_s;

	// reset values: overrides off means automatic switchover
	localparam srxa_ctrl_s SRXA_CTRL_RST = '{quad: 1'b0, low7: 1'b0,
		chan_used: 1'b1, dbl: 1'b0, wide10: 1'b1, ppm_sel: 2'h0,
		frc_ref: 1'b0, frc_data: 1'b0};
	localparam srxa_mode_s SRXA_MODE_RST = '{proto: PR_CUSTOM,
		amode: AM_P10};
	localparam logic [15:0] SRXA_PAT_RST = 16'h017C;
	localparam logic [4:0] SRXA_RL_RST = 5'h1F;

	// lock detector frequency thresholds in ppm
	localparam logic [10:0] SRXA_PPM_125 = 11'h07D;
	localparam logic [10:0] SRXA_PPM_250 = 11'h0FA;
	localparam logic [10:0] SRXA_PPM_500 = 11'h1F4;
	localparam logic [10:0] SRXA_PPM_1000 = 11'h3E8;

	// comma code group, first bit received in bit 0
	localparam logic [9:0] SRXA_K285_NEG = 10'h17C;
	localparam logic [9:0] SRXA_K285_POS = 10'h283;

	// run length steps and sync machine counts
	localparam logic [8:0] SRXA_RL_STEP10 = 9'h005;
	localparam logic [8:0] SRXA_RL_STEP8 = 9'h004;
	localparam logic [1:0] SRXA_ACQ_CNT = 2'h3;
	localparam logic [2:0] SRXA_LOSS_CNT = 3'h4;
	localparam logic [3:0] SRXA_W10 = 4'hA;
	localparam logic [3:0] SRXA_W8 = 4'h8;

endpackage

// [hw/srxa_top.sv]
// Purpose: clock recovery lock control, deserializer and word aligner
// Assumes: line bits arrive as data plus strobe pins, one bit per strobe
// Notes: fabric controls and the ppm measurement share pclk
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps

// What this block does
// R1: force-data gives data lock; else force-reference; else automatic.
// R2: with both overrides untouched the unit runs in automatic switchover.
// R3: automatic mode goes to data lock only within ppm threshold and phase.
// R4: frequency threshold selectable among 125, 250, 500 and 1000 ppm.
// R5: status output shows the unit is locked to data.
// R6: active-low status output shows lock to the reference clock.
// R7: run length threshold 5..160 step 5, or 4..128 step 4.
// R8: each channel has its own loop; an unused channel powers it down.
// R9: serial bits gather into 8 or 10 bit words, first bit lsb.
// R10: aligner modes bit-slip, 16-bit, 10-bit, plus XAUI and Ethernet.
// R11: each slip request moves the word boundary by exactly one bit.
// R12: bit-slip works on 8 and 10 bit paths, single or double width.
// R13: in bit-slip mode the pattern detector still reports the pattern.
// R14: bit-slip only in custom and SONET configurations.
// R15: 16-bit mode finds the 16-bit pattern and aligns to it.
// R16: four-byte pattern only in SONET; custom uses two bytes.
// R17: in 16-bit mode user logic can request re-alignment.
// R18: 16-bit mode only with the 8-bit data path.
// R19: 10-bit mode matches all ten bits or only the lower seven.
// R20: 10-bit mode matches both disparity forms of the pattern.
// R21: 10-bit mode aligns only while enabled; custom configuration only.
// R22: protocol modes align on the comma under a sync state machine.
// R23: pattern flag comes with the word holding the pattern.
// R24: boundary holds until slip, re-align or sync machine decision.
module srxa_top import srxa_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire logic rx_serial_bit,
	input wire logic rx_bit_valid,
	input wire logic phase_in_tol,
	input wire logic [10:0] freq_err_ppm,
	input wire logic slip_req,
	input wire logic realign_req,
	input wire logic align_en,
	output logic [19:0] rx_word_q,
	output logic rx_word_valid_q,
	output logic pat_detect_q,
	output logic freq_locked_q,
	output logic ref_locked_n_q,
	output logic clock_recovery_unit_off_q,
	output logic runlen_err_q,
	output logic rx_sync_q
);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [2:0] pin_s1_q, pin_s2_q;
	logic bit_d, bit_v, phase_ok;
	srxa_ctrl_s ctrl_q, new_ctrl;
	srxa_mode_s mode_q, new_mode;
	logic [15:0] pat_q;
	logic [4:0] rl_sel_q;

	// only the second stage is read by logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= {phase_in_tol, rx_bit_valid, rx_serial_bit};
			pin_s2_q <= pin_s1_q;
		end
	end
	assign bit_d = pin_s2_q[0];
	assign bit_v = pin_s2_q[1];
	assign phase_ok = pin_s2_q[2];

	////////////////////////////////////////////////////////////////////
	// apb slave, one wait state so read data comes from a flop
	logic apb_acc, dec_err, wr_err;
	logic [31:0] rd_data;
	srxa_stat_s stat;

	// legality of a mode against protocol and data path
	function automatic logic mode_legal(srxa_ctrl_s c, srxa_mode_s m);
		logic ok;
		ok = !(c.quad && m.proto != PR_SONET); // R16
		case (m.amode)
			AM_SLIP: ok = ok
				&& (m.proto == PR_CUSTOM || m.proto == PR_SONET); // R14
			AM_P16: ok = ok && !c.wide10
				&& (m.proto == PR_CUSTOM || m.proto == PR_SONET); // R18
			AM_P10: ok = ok && c.wide10 && m.proto == PR_CUSTOM; // R21
			AM_XAUI: ok = ok && c.wide10 && m.proto == PR_XAUI; // R22
			AM_GIGABIT_ETHERNET: ok = ok && c.wide10
				&& m.proto == PR_GIGABIT_ETHERNET; // R22
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	assign apb_acc = psel && penable;

	// address decode and read mux
	always_comb begin
		new_ctrl = ctrl_q;
		new_mode = mode_q;
		rd_data = 32'h0;
		dec_err = 1'b0;
		if (paddr == SRXA_OFS_CTRL) begin
			new_ctrl = srxa_ctrl_s'(pwdata[$bits(srxa_ctrl_s)-1:0]);
			rd_data = 32'(ctrl_q);
		end else if (paddr == SRXA_OFS_MODE) begin
			new_mode = srxa_mode_s'(pwdata[$bits(srxa_mode_s)-1:0]);
			rd_data = 32'(mode_q);
		end else if (paddr == SRXA_OFS_PAT) begin
			rd_data = 32'(pat_q);
		end else if (paddr == SRXA_OFS_RUNLEN) begin
			rd_data = 32'(rl_sel_q);
		end else if (paddr == SRXA_OFS_STAT) begin
			rd_data = 32'(stat);
		end else begin
			dec_err = 1'b1;
		end
		// an illegal mode combination is refused, nothing is stored
		wr_err = dec_err || (pwrite && !mode_legal(new_ctrl, new_mode));
	end

	// answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= apb_acc && !pready_q;
			if (apb_acc && !pready_q) begin
				prdata_q <= pwrite ? 32'h0 : rd_data;
				pslverr_q <= wr_err;
			end
		end
	end

	// configuration written at the completing edge; reset means auto lock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= SRXA_CTRL_RST; // R2
			mode_q <= SRXA_MODE_RST;
			pat_q <= SRXA_PAT_RST;
			rl_sel_q <= SRXA_RL_RST;
		end else if (apb_acc && pready_q && pwrite && !pslverr_q) begin
			if (paddr == SRXA_OFS_CTRL || paddr == SRXA_OFS_MODE) begin
				ctrl_q <= new_ctrl;
				mode_q <= new_mode;
			end else if (paddr == SRXA_OFS_PAT) begin
				pat_q <= pwdata[15:0];
			end else if (paddr == SRXA_OFS_RUNLEN) begin
				rl_sel_q <= pwdata[4:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// clock recovery lock control
	logic [10:0] ppm_thr;
	logic freq_ok, lock_ok, lock_d;

	// static threshold pick
	always_comb begin
		case (ctrl_q.ppm_sel)
			2'h0: ppm_thr = SRXA_PPM_125; // R4
			2'h1: ppm_thr = SRXA_PPM_250;
			2'h2: ppm_thr = SRXA_PPM_500;
			default: ppm_thr = SRXA_PPM_1000;
		endcase
	end
	assign freq_ok = freq_err_ppm <= ppm_thr;
	assign lock_ok = freq_ok && phase_ok; // R3

	// data lock drops back to reference once frequency drifts out
	always_comb begin
		if (!ctrl_q.chan_used) begin
			lock_d = 1'b0; // R8
		end else if (ctrl_q.frc_data) begin
			lock_d = 1'b1; // R1
		end else if (ctrl_q.frc_ref) begin
			lock_d = 1'b0; // R1
		end else if (!freq_locked_q) begin
			lock_d = lock_ok; // R3
		end else begin
			lock_d = freq_ok;
		end
	end

	// lock status and per-channel power down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_locked_q <= 1'b0;
			ref_locked_n_q <= 1'b1;
			clock_recovery_unit_off_q <= 1'b1;
		end else begin
			freq_locked_q <= lock_d; // R5
			ref_locked_n_q <= !(ctrl_q.chan_used && !lock_d); // R6
			clock_recovery_unit_off_q <= !ctrl_q.chan_used; // R8
		end
	end

	////////////////////////////////////////////////////////////////////
	// deserializer and pattern match
	logic [31:0] hist_q, hist_n;
	logic [3:0] bcnt_q, wid;
	logic [9:0] cur, lo_q, mask;
	logic m10, m16, mcomma, pmatch, align_go, bnd, realign, emit;
	logic slip_pend_q, arm_q, half_q, pm_lo_q;
	logic [1:0] acq_q;
	logic [2:0] bad_q;
	srxa_sync_e sync_q, sync_d;

	assign wid = ctrl_q.wide10 ? SRXA_W10 : SRXA_W8;
	assign hist_n = {bit_d, hist_q[31:1]}; // R9
	assign cur = ctrl_q.wide10 ? hist_n[31:22] : {2'h0, hist_n[31:24]};
	assign mask = ctrl_q.low7 ? 10'h07F : 10'h3FF; // R19
	assign m10 = (((hist_n[31:22] ^ pat_q[9:0]) & mask) == 10'h0)
		|| (((hist_n[31:22] ^ ~pat_q[9:0]) & mask) == 10'h0); // R20
	assign m16 = ctrl_q.quad
		? hist_n == {pat_q[15:8], pat_q[15:8], pat_q[7:0], pat_q[7:0]}
		: hist_n[31:16] == pat_q; // R16
	assign mcomma = hist_n[31:22] == SRXA_K285_NEG
		|| hist_n[31:22] == SRXA_K285_POS; // R22

	// pattern source and permission to move the boundary per mode
	always_comb begin
		case (mode_q.amode)
			AM_SLIP: begin
				pmatch = ctrl_q.wide10 ? m10 : m16; // R13
				align_go = 1'b0;
			end
			AM_P16: begin
				pmatch = m16; // R15
				align_go = arm_q;
			end
			AM_P10: begin
				pmatch = m10;
				align_go = align_en; // R21
			end
			default: begin
				pmatch = mcomma; // R10
				align_go = sync_q != SY_SYNC; // R22
			end
		endcase
	end

	assign bnd = bcnt_q + 4'h1 == wid;
	assign realign = pmatch && align_go && !bnd;
	assign emit = bit_v && !slip_pend_q && (bnd || (pmatch && align_go));

	// boundary counter; otherwise free running so the boundary holds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_q <= 32'h0;
			bcnt_q <= 4'h0;
		end else if (bit_v) begin
			hist_q <= hist_n;
			if (slip_pend_q) begin
				bcnt_q <= bcnt_q; // R11
			end else if (emit) begin
				bcnt_q <= 4'h0; // R24
			end else begin
				bcnt_q <= bcnt_q + 4'h1;
			end
		end
	end

	// a new request in the consuming cycle stays pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slip_pend_q <= 1'b0;
			arm_q <= 1'b1;
		end else begin
			if (slip_req && mode_q.amode == AM_SLIP) begin
				slip_pend_q <= 1'b1; // R11
			end else if (bit_v) begin
				slip_pend_q <= 1'b0;
			end
			if (realign_req && mode_q.amode == AM_P16) begin
				arm_q <= 1'b1; // R17
			end else if (emit && pmatch && mode_q.amode == AM_P16) begin
				arm_q <= 1'b0;
			end
		end
	end

	// word output, pairs in double width with the first word low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_word_q <= 20'h0;
			rx_word_valid_q <= 1'b0;
			pat_detect_q <= 1'b0;
			lo_q <= 10'h0;
			half_q <= 1'b0;
			pm_lo_q <= 1'b0;
		end else begin
			rx_word_valid_q <= 1'b0;
			pat_detect_q <= 1'b0;
			if (emit && (!ctrl_q.dbl)) begin
				rx_word_q <= {10'h0, cur};
				rx_word_valid_q <= 1'b1;
				pat_detect_q <= pmatch; // R23
			end else if (emit && (realign || !half_q)) begin
				lo_q <= cur; // R12
				pm_lo_q <= pmatch;
				half_q <= 1'b1;
			end else if (emit) begin
				rx_word_q <= ctrl_q.wide10 ? {cur, lo_q}
					: {4'h0, cur[7:0], lo_q[7:0]}; // R12
				rx_word_valid_q <= 1'b1;
				pat_detect_q <= pmatch || pm_lo_q; // R23
				half_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// run length detector
	logic [7:0] run_q, run_n, rl_thr;
	assign rl_thr = 8'((9'(rl_sel_q) + 9'h001)
		* (ctrl_q.wide10 ? SRXA_RL_STEP10 : SRXA_RL_STEP8)); // R7
	assign run_n = (bit_d != hist_q[31]) ? 8'h01
		: (run_q == 8'hFF ? run_q : run_q + 8'h01);

	// counts identical bits in a row, flag follows each bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 8'h0;
			runlen_err_q <= 1'b0;
		end else if (bit_v) begin
			run_q <= run_n;
			runlen_err_q <= run_n >= rl_thr; // R7
		end
	end

	////////////////////////////////////////////////////////////////////
	// protocol synchronisation machine, comma based
	logic mode_leave;
	// a write leaving the protocol modes drops the sync flag at once,
	// otherwise it would stand one cycle into the new mode
	assign mode_leave = apb_acc && pready_q && pwrite && !pslverr_q
		&& new_mode.amode != AM_XAUI
		&& new_mode.amode != AM_GIGABIT_ETHERNET;

	always_comb begin
		sync_d = sync_q;
		if (mode_q.amode != AM_XAUI
			&& mode_q.amode != AM_GIGABIT_ETHERNET) begin
			sync_d = SY_LOSS;
		end else begin
			case (sync_q)
				SY_LOSS: if (emit && mcomma) sync_d = SY_ACQ; // R22
				SY_ACQ: if (emit && mcomma && acq_q + 2'h1 == SRXA_ACQ_CNT)
					sync_d = SY_SYNC; // R22
				SY_SYNC: if (bit_v && mcomma && !emit
					&& bad_q + 3'h1 == SRXA_LOSS_CNT) sync_d = SY_LOSS;
				default: sync_d = SY_LOSS;
			endcase
		end
	end

	// comma counters; a misaligned comma while in sync counts as bad
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= SY_LOSS;
			acq_q <= 2'h0;
			bad_q <= 3'h0;
			rx_sync_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			rx_sync_q <= sync_d == SY_SYNC && !mode_leave; // R22
			if (sync_d != SY_ACQ) begin
				acq_q <= 2'h0;
			end else if (emit && mcomma) begin
				acq_q <= acq_q + 2'h1;
			end
			if (sync_d != SY_SYNC || (emit && mcomma)) begin
				bad_q <= 3'h0;
			end else if (bit_v && mcomma) begin
				bad_q <= bad_q + 3'h1;
			end
		end
	end

	assign stat = '{in_sync: rx_sync_q, runlen_err: runlen_err_q,
		unit_off: clock_recovery_unit_off_q,
		ref_locked_n: ref_locked_n_q,
		freq_locked: freq_locked_q, realign_armed: arm_q};

	////////////////////////////////////////////////////////////////////
	// assertions
	property p_force_data;
		ctrl_q.frc_data && ctrl_q.chan_used |=> freq_locked_q;
	endproperty
	a_force_data: assert property (p_force_data) // R1
		else $error("force data did not lock to data");

	property p_force_ref;
		!ctrl_q.frc_data && ctrl_q.frc_ref |=> !freq_locked_q;
	endproperty
	a_force_ref: assert property (p_force_ref) // R1
		else $error("force reference did not hold reference lock");

	property p_auto_cond;
		!ctrl_q.frc_data && !ctrl_q.frc_ref && !freq_locked_q
			##1 freq_locked_q |-> $past(lock_ok);
	endproperty
	a_auto_cond: assert property (p_auto_cond) // R3
		else $error("data lock taken outside ppm or phase window");

	property p_ref_flag;
		!clock_recovery_unit_off_q && $past(ctrl_q.chan_used)
			|-> ref_locked_n_q == freq_locked_q;
	endproperty
	a_ref_flag: assert property (p_ref_flag) // R6
		else $error("reference lock flag disagrees with lock state");

	property p_power_down;
		!ctrl_q.chan_used |=> clock_recovery_unit_off_q && !freq_locked_q
			&& ref_locked_n_q;
	endproperty
	a_power_down: assert property (p_power_down) // R8
		else $error("unused channel loop not powered down");

	property p_slip_hold;
		slip_pend_q && bit_v && !slip_req |=> !slip_pend_q
			&& bcnt_q == $past(bcnt_q) && !rx_word_valid_q;
	endproperty
	a_slip_hold: assert property (p_slip_hold) // R11
		else $error("slip did not hold the boundary for one bit");

	property p_runlen;
		$rose(runlen_err_q) |-> $past(run_n) >= $past(rl_thr);
	endproperty
	a_runlen: assert property (p_runlen) // R7
		else $error("run length flag below threshold");

	property p_pat_word;
		pat_detect_q |-> rx_word_valid_q;
	endproperty
	a_pat_word: assert property (p_pat_word) // R23
		else $error("pattern flag without its word");

	property p_quad_sonet;
		ctrl_q.quad |-> mode_q.proto == PR_SONET;
	endproperty
	a_quad_sonet: assert property (p_quad_sonet) // R16
		else $error("four byte pattern outside SONET");

	property p_sync_mode;
		rx_sync_q |-> mode_q.amode == AM_XAUI
			|| mode_q.amode == AM_GIGABIT_ETHERNET;
	endproperty
	a_sync_mode: assert property (p_sync_mode) // R22
		else $error("sync reported outside protocol modes");

	c_data_lock: cover property (!freq_locked_q ##1 freq_locked_q);
	c_slip: cover property (slip_pend_q && bit_v);
	c_realign: cover property (bit_v && realign ##[1:40] pat_detect_q);
	c_sync: cover property ($rose(rx_sync_q));

endmodule // srxa_top

// [testbench/srxa_line_tx.sv]
// Purpose: remote serial transmitter model for the receive aligner
// Assumes: one bit per strobe cycle, first bit is the word lsb
// Notes: gap adds idle cycles after each bit for a slow sender
`timescale 1ns/100ps
module srxa_line_tx (
	input wire logic pclk,
	output logic ser,
	output logic strb
);
	// idle line at time zero
	initial begin
		ser = 1'b0;
		strb = 1'b0;
	end

	// send n bits lsb first; idle shows the inverted last bit so stale
	// data can never pass for a fresh bit
	task automatic send(input logic [19:0] w, input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			ser <= w[i];
			strb <= 1'b1;
			for (int g = 0; g < gap; g++) begin
				@(posedge pclk);
				strb <= 1'b0;
				ser <= ~w[i];
			end
		end
		@(posedge pclk);
		strb <= 1'b0;
		ser <= ~w[n-1];
	endtask
endmodule // srxa_line_tx

// [testbench/testbench.sv]
// Purpose: self-checking bench for receive lock and word aligner
// Assumes: apb master per pready, line bits from srxa_line_tx
// Notes: tests run in order; each leaves the config for the next
`timescale 1ns/100ps
module testbench import srxa_pkg::*; ;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic phase_in_tol = 1'b0;
	logic [10:0] freq_err_ppm = 11'h000;
	logic slip_req = 1'b0;
	logic realign_req = 1'b0;
	logic align_en = 1'b0;
	logic [31:0] prdata_q, rd;
	logic pready_q, pslverr_q, err, rx_serial_bit, rx_bit_valid;
	logic rx_word_valid_q, pat_detect_q, freq_locked_q, ref_locked_n_q;
	logic clock_recovery_unit_off_q, runlen_err_q, rx_sync_q;
	logic [19:0] rx_word_q, msk;
	logic [19:0] wq[$];
	logic pq[$];
	int num_errors = 0;
	int samples_checked = 0;

	srxa_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata_q, .pready_q, .pslverr_q, .rx_serial_bit,
		.rx_bit_valid, .phase_in_tol, .freq_err_ppm, .slip_req,
		.realign_req, .align_en, .rx_word_q, .rx_word_valid_q,
		.pat_detect_q, .freq_locked_q, .ref_locked_n_q,
		.clock_recovery_unit_off_q, .runlen_err_q, .rx_sync_q);
	srxa_line_tx line (.pclk, .ser(rx_serial_bit), .strb(rx_bit_valid));

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// collect every word with its pattern flag
	always @(posedge pclk) begin
		if (rx_word_valid_q === 1'b1) begin
			wq.push_back(rx_word_q);
			pq.push_back(pat_detect_q);
		end
	end

	////////////////////////////////////////
	// compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready_q !== 1'b1);
		rd = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// last sighting of a word: {seen, pattern flag}
	function automatic logic [1:0] look(input logic [19:0] w);
		logic [1:0] r = 2'b00;
		foreach (wq[i])
			if (wq[i] === w)
				r = {1'b1, pq[i]};
		return r;
	endfunction

	// junk offset, then pattern, then alternating data, slow then fast
	task automatic burst(input logic [19:0] p, input int n);
		wq.delete();
		pq.delete();
		line.send(20'h5, 3, 0);
		line.send(p, n, 0);
		line.send(20'h2AA, 10, 1);
		line.send(20'h2AA, 10, 0);
		cyc(8);
	endtask

	// one slip per step; every rotation of a lone one must show up
	task automatic sweep(input int n);
		msk = 20'h0;
		for (int k = 0; k < n; k++) begin
			@(posedge pclk);
			slip_req <= 1'b1;
			@(posedge pclk);
			slip_req <= 1'b0;
			line.send(20'h1, n, 0);
			line.send(20'h1, n, 0);
			cyc(8);
			msk = msk | wq[$];
		end
		chk("slip set", 32'(20'hFFFFF >> (20 - n)), 32'(msk));
	endtask

	////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		apb(1'b0, SRXA_OFS_CTRL, 32'h0);
		chk("ctrl", 32'h50, rd);
		apb(1'b0, SRXA_OFS_MODE, 32'h0);
		chk("mode", 32'h2, rd);
		apb(1'b0, SRXA_OFS_PAT, 32'h0);
		chk("pat", 32'h17C, rd);
		apb(1'b0, SRXA_OFS_RUNLEN, 32'h0);
		chk("runlen", 32'h1F, rd);
		apb(1'b0, SRXA_OFS_STAT, 32'h0);
		chk("stat", 32'h1, rd);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'h1, 32'(err));
		chk("pd", 32'h0, 32'(clock_recovery_unit_off_q));
		chk("refn", 32'h0, 32'(ref_locked_n_q));
		$display("test reset done");
	endtask

	task automatic t_lock();
		logic [8:0] c[6] = '{9'h50, 9'h51, 9'h53, 9'h52, 9'h52, 9'h50};
		logic [1:0] ex[6] = '{2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 2'h3};
		logic [10:0] th[4] = '{SRXA_PPM_125, SRXA_PPM_250,
			SRXA_PPM_500, SRXA_PPM_1000};
		freq_err_ppm <= 11'h7FF;
		for (int i = 0; i < 6; i++) begin
			if (i == 4) begin
				freq_err_ppm <= 11'h000;
				phase_in_tol <= 1'b1;
			end
			apb(1'b1, SRXA_OFS_CTRL, {23'h0, c[i]});
			cyc(6);
			chk("lock", 32'(ex[i]),
				32'({freq_locked_q, ref_locked_n_q}));
		end
		for (int s = 0; s < 4; s++) begin
			freq_err_ppm <= th[s] + 11'h001;
			apb(1'b1, SRXA_OFS_CTRL, 32'h50 + 32'(4 * s));
			cyc(6);
			chk("over", 32'h0, 32'(freq_locked_q));
			freq_err_ppm <= th[s];
			cyc(6);
			chk("at", 32'h1, 32'(freq_locked_q));
		end
		freq_err_ppm <= 11'h7FF;
		phase_in_tol <= 1'b0;
		cyc(6);
		freq_err_ppm <= 11'h000;
		cyc(6);
		chk("phase", 32'h0, 32'(freq_locked_q));
		$display("test lock done");
	endtask

	task automatic t_p10();
		apb(1'b1, SRXA_OFS_CTRL, 32'h50);
		align_en <= 1'b1;
		burst(20'h17C, 10);
		chk("neg", 32'h3, 32'(look(20'h17C)));
		chk("data", 32'h1, 32'(look(20'h2AA) >> 1));
		burst(20'h283, 10);
		chk("pos", 32'h3, 32'(look(20'h283)));
		align_en <= 1'b0;
		burst(20'h17C, 10);
		chk("held", 32'h0, 32'(look(20'h2AA) >> 1));
		align_en <= 1'b1;
		apb(1'b1, SRXA_OFS_CTRL, 32'hD0);
		burst(20'h27C, 10);
		chk("low7", 32'h3, 32'(look(20'h27C)));
		// double width: realigned pattern becomes the low half of a pair
		apb(1'b1, SRXA_OFS_CTRL, 32'hF0);
		burst(20'h27C, 10);
		chk("pair", 32'h3, 32'(look(20'hAAA7C)));
		$display("test p10 done");
	endtask

	task automatic t_proto();
		logic [4:0] md[2] = '{5'h13, 5'h1C};
		apb(1'b1, SRXA_OFS_CTRL, 32'h50);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, SRXA_OFS_MODE, {27'h0, md[m]});
			chk("mode err", 32'h0, 32'(err));
			for (int k = 0; k < 5; k++) begin
				line.send(20'h283, 10, 0);
				line.send(20'h2AA, 10, 0);
			end
			cyc(8);
			chk("sync", 32'h1, 32'(rx_sync_q));
			// four misaligned commas while in sync drop it
			for (int k = 0; k < 4; k++) begin
				line.send(20'h1, 1, 0);
				line.send(20'h17C, 10, 0);
			end
			cyc(8);
			chk("lost", 32'h0, 32'(rx_sync_q));
			// pad back to a word boundary for the next test
			line.send(20'h2A, 6, 0);
		end
		$display("test proto done");
	endtask

	task automatic t_slip();
		apb(1'b1, SRXA_OFS_MODE, 32'h0);
		chk("slip err", 32'h0, 32'(err));
		wq.delete();
		pq.delete();
		line.send(20'h17C, 10, 0);
		cyc(8);
		chk("slip pat", 32'h3, 32'(look(20'h17C)));
		sweep(10);
		apb(1'b1, SRXA_OFS_CTRL, 32'h40);
		chk("w8 err", 32'h0, 32'(err));
		sweep(8);
		apb(1'b1, SRXA_OFS_RUNLEN, 32'h0);
		line.send(20'h11, 8, 0);
		line.send(20'h11, 8, 0);
		cyc(6);
		chk("run3", 32'h0, 32'(runlen_err_q));
		line.send(20'h0F, 8, 0);
		cyc(6);
		chk("run4", 32'h1, 32'(runlen_err_q));
		$display("test slip done");
	endtask

	task automatic t_p16();
		apb(1'b1, SRXA_OFS_PAT, 32'h28F6);
		apb(1'b1, SRXA_OFS_MODE, 32'h1);
		chk("p16 err", 32'h0, 32'(err));
		burst(20'h28F6, 16);
		chk("p16 pat", 32'h3, 32'(look(20'h28)));
		chk("p16 data", 32'h1, 32'(look(20'hAA) >> 1));
		apb(1'b0, SRXA_OFS_STAT, 32'h0);
		chk("disarm", 32'h0, 32'(rd[0]));
		burst(20'h28F6, 16);
		chk("kept", 32'h0, 32'(look(20'hAA) >> 1));
		@(posedge pclk);
		realign_req <= 1'b1;
		@(posedge pclk);
		realign_req <= 1'b0;
		apb(1'b0, SRXA_OFS_STAT, 32'h0);
		chk("arm", 32'h1, 32'(rd[0]));
		burst(20'h28F6, 16);
		chk("realign", 32'h1, 32'(look(20'hAA) >> 1));
		$display("test p16 done");
	endtask

	task automatic t_bad();
		logic [7:0] a[7] = '{SRXA_OFS_MODE, SRXA_OFS_MODE, SRXA_OFS_MODE,
			SRXA_OFS_CTRL, SRXA_OFS_CTRL, SRXA_OFS_MODE, SRXA_OFS_CTRL};
		logic [8:0] d[7] = '{9'h2, 9'h13, 9'h10, 9'h50, 9'h140, 9'h9,
			9'h140};
		logic e[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, a[i], {23'h0, d[i]});
			chk("refuse", 32'(e[i]), 32'(err));
		end
		apb(1'b0, SRXA_OFS_MODE, 32'h0);
		chk("mode kept", 32'h9, rd);
		apb(1'b1, SRXA_OFS_CTRL, 32'h100);
		cyc(4);
		chk("pd", 32'h1, 32'(clock_recovery_unit_off_q));
		$display("test config done");
	endtask

	////////////////////////////////////////
	// verdict, shared by the main sequence and the watchdog
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_lock();
		t_p10();
		t_proto();
		t_slip();
		t_p16();
		t_bad();
		report_and_stop();
	end

	// watchdog: tests need well under 10k cycles
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
endmodule // testbench
